// file: rtl/ctp_timer_cfg.svh
// constants for the cascaded timer pair
`ifndef CTP_TIMER_CFG_SVH
`define CTP_TIMER_CFG_SVH
`define CTP_CS_CASCADE 3'h4
`define CTP_CS_INT1    3'h1
`define CTP_CS_INT2    3'h2
`define CTP_CS_INT3    3'h3
`define CTP_DIV_BIT1   1
`define CTP_DIV_BIT2   3
`define CTP_DIV_BIT3   5
`define CTP_CLR_MA     2'h1
`define CTP_CLR_MB     2'h2
`define CTP_CLR_EXT    2'h3
`define CTP_PIN_ZERO   2'h1
`define CTP_PIN_ONE    2'h2
`define CTP_PIN_TOG    2'h3
`define CTP_CNT_RST    8'h00
`define CTP_COR_RST    8'hff
`define CTP_CNT_TOP    8'hff
`endif

// file: rtl/ctp_pkg.sv
// types shared by the cascaded timer pair
package ctp_pkg;
    // per-channel software configuration
    typedef struct packed {
        logic [2:0] count_clock_select;
        logic       clear_select_high;
        logic       clear_select_low;
        logic [3:0] pin_action_select;     // [1:0] match a, [3:2] match b
        logic       match_a_interrupt_enable;
        logic       match_b_interrupt_enable;
        logic       overflow_interrupt_enable;
    } ctp_cfg_s;
    // per-channel flags, also used as clear strobes
    typedef struct packed {
        logic a;
        logic b;
        logic ov;
    } ctp_flag_s;
    // per-channel state
    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] cora;
        logic [7:0] corb;
        ctp_flag_s  flag;
        logic       pin;
        logic       clk_prev;
    } ctp_chan_s;
    // result of one channel step
    typedef struct packed {
        ctp_chan_s ch;
        logic      ma;
        logic      mb;
        logic      ov;
    } ctp_step_s;
    // write target select
    typedef enum logic [2:0] {
        CTP_W_CNT_HI  = 3'h0,
        CTP_W_CNT_LO  = 3'h1,
        CTP_W_CORA_HI = 3'h2,
        CTP_W_CORB_HI = 3'h3,
        CTP_W_CORA_LO = 3'h4,
        CTP_W_CORB_LO = 3'h5
    } ctp_wsel_e;
    // whole block state
    typedef struct packed {
        ctp_chan_s  hi;
        ctp_chan_s  lo;
        logic [7:0] presc;
        logic [7:0] cap_rise;
        logic [7:0] cap_fall;
        logic       cap_s1;
        logic       cap_s2;
        logic       cap_prev;
        logic       cap_arm;
        logic       cap_pend;
        logic       cap_flag;
        logic       clr_s1;
        logic       clr_s2;
        logic       clr_prev;
        logic       run;
    } ctp_state_s;
endpackage

// file: rtl/ctp_timer_pair.sv
// cascaded 8-bit timer pair with input capture on the lower channel
`timescale 1ns/1ps
`include "ctp_timer_cfg.svh"
module ctp_timer_pair
    import ctp_pkg::*;
(
    input  wire logic       clk_sys,                     // system clock
    input  wire logic       rst_b,                       // async reset, low
    input  wire logic       module_stop,                 // 1 halts the block
    input  wire ctp_cfg_s   cfg_hi,                      // upper channel setup
    input  wire ctp_cfg_s   cfg_lo,                      // lower channel setup
    input  wire logic       upper_cascade_select,        // 16-bit mode select
    input  wire logic       lower_cascade_select,        // match count select
    input  wire logic       capture_source_select,       // capture enable
    input  wire logic       capture_interrupt_enable,    // capture req enable
    input  wire logic       capture_input_signal,        // capture pin
    input  wire logic       upper_external_clear_input,  // upper clear pin
    input  wire logic       wr_en,                       // write strobe
    input  wire ctp_wsel_e  wr_sel,                      // write target
    input  wire logic [7:0] wr_data,                     // write data
    input  wire logic       cap_rd,                      // capture regs read
    input  wire ctp_flag_s  flag_clr_hi,                 // upper flag clears
    input  wire ctp_flag_s  flag_clr_lo,                 // lower flag clears
    input  wire logic       capture_flag_clear,          // capture flag clear
    output logic [7:0]      up_counter_hi,               // upper count
    output logic [7:0]      up_counter_lo,               // lower count
    output logic [7:0]      capture_rise_register,       // capture copy 1
    output logic [7:0]      capture_fall_register,       // capture copy 2
    output ctp_flag_s       flags_hi,                    // upper flags
    output ctp_flag_s       flags_lo,                    // lower flags
    output logic            capture_flag,                // capture flag
    output logic            upper_timer_output,          // upper pin
    output logic            lower_timer_output,          // lower pin
    output logic            match_a_interrupt,           // shared match a req
    output logic            match_b_interrupt,           // shared match b req
    output logic            overflow_interrupt,          // shared overflow req
    output logic            capture_interrupt,           // capture req
    output logic            irq_any,                     // some request up
    output logic [1:0]      irq_top                      // highest request
);

    // ****************************************
    // functions
    // ****************************************

    // level of the selected internal clock; stop and cascade read low
    function automatic logic clk_level(logic [2:0] cs, logic [7:0] p);
        logic l;
        l = 1'b0;
        if (cs == `CTP_CS_INT1) begin
            l = p[`CTP_DIV_BIT1];
        end else if (cs == `CTP_CS_INT2) begin
            l = p[`CTP_DIV_BIT2];
        end else if (cs == `CTP_CS_INT3) begin
            l = p[`CTP_DIV_BIT3];
        end
        return l;
    endfunction

    // match is raised only when the counter moves off the equal value
    function automatic logic match_hit(logic [7:0] c, logic [7:0] r,
                                       logic evt, logic blk);
        return evt && (c == r) && !blk;
    endfunction

    // one step of a channel: count, clear, write, flags and pin
    function automatic ctp_step_s chan_step(ctp_chan_s c, ctp_cfg_s g,
                                            logic evt, logic ext,
                                            logic wcnt, logic wa,
                                            logic wb, logic sup,
                                            logic [7:0] wd,
                                            ctp_flag_s clr);
        ctp_step_s  s;
        logic [1:0] sel;
        logic [1:0] act_a;
        logic [1:0] act_b;
        logic [1:0] act;
        logic       clear;
        s     = '{ch: c, ma: 1'b0, mb: 1'b0, ov: 1'b0};
        sel   = {g.clear_select_high, g.clear_select_low};
        s.ma  = match_hit(c.cnt, c.cora, evt, wa | sup);
        s.mb  = match_hit(c.cnt, c.corb, evt, wb | sup);
        clear = ((sel == `CTP_CLR_MA) && s.ma) ||
                ((sel == `CTP_CLR_MB) && s.mb) ||
                ((sel == `CTP_CLR_EXT) && ext);
        s.ov  = evt && !clear && !wcnt && (c.cnt == `CTP_CNT_TOP);
        // clear first, then the write, then the count-up
        if (clear) begin
            s.ch.cnt = `CTP_CNT_RST;
        end else if (wcnt) begin
            s.ch.cnt = wd;
        end else if (evt) begin
            s.ch.cnt = c.cnt + 8'h01;
        end
        if (wa) begin
            s.ch.cora = wd;
        end
        if (wb) begin
            s.ch.corb = wd;
        end
        // a new event wins over a clear in the same cycle
        s.ch.flag.a  = s.ma | (c.flag.a & !clr.a);
        s.ch.flag.b  = s.mb | (c.flag.b & !clr.b);
        s.ch.flag.ov = s.ov | (c.flag.ov & !clr.ov);
        // action codes rise with priority, so the larger one wins
        act_a = s.ma ? g.pin_action_select[1:0] : 2'h0;
        act_b = s.mb ? g.pin_action_select[3:2] : 2'h0;
        act   = (act_a > act_b) ? act_a : act_b;
        case (act)
            `CTP_PIN_ZERO: begin
                s.ch.pin = 1'b0;
            end
            `CTP_PIN_ONE: begin
                s.ch.pin = 1'b1;
            end
            `CTP_PIN_TOG: begin
                s.ch.pin = !c.pin;
            end
            default: begin
                s.ch.pin = c.pin;
            end
        endcase
        return s;
    endfunction

    // ****************************************
    // state
    // ****************************************

    ctp_state_s st_reg;   // all block state
    ctp_state_s st_next;  // its next value

    ctp_step_s  step_hi;  // upper step result
    ctp_step_s  step_lo;  // lower step result

    // ****************************************
    // next state
    // ****************************************

    // one pass computes the whole pair; lower runs on a precomputed
    // upper match so no loop forms between the two steps
    always_comb begin
        logic       m16;
        logic       mcm;
        logic       lvl_hi;
        logic       lvl_lo;
        logic       base_hi;
        logic       base_lo;
        logic       evt_hi;
        logic       evt_lo;
        logic       ma_pre;
        logic       rise;
        logic       fall;
        logic       cap_go;
        logic       cap_fire;
        logic       ext_clr;
        logic       wcnt_hi;
        logic       wcnt_lo;
        logic       wa_hi;
        logic       wb_hi;
        logic       wa_lo;
        logic       wb_lo;
        st_next = st_reg;
        evt_hi  = 1'b0;
        evt_lo  = 1'b0;
        // halted until the system releases module stop
        st_next.run = !module_stop;
        // prescaler cleared to zero while halted
        st_next.presc = st_reg.run ? (st_reg.presc + 8'h01) : 8'h00;
        // mode decode
        m16 = (cfg_hi.count_clock_select == `CTP_CS_CASCADE) &&
              upper_cascade_select;
        mcm = (cfg_lo.count_clock_select == `CTP_CS_CASCADE) &&
              lower_cascade_select;
        // falling edge of the selected level, glitch on switch included
        lvl_hi  = clk_level(cfg_hi.count_clock_select, st_reg.presc);
        lvl_lo  = clk_level(cfg_lo.count_clock_select, st_reg.presc);
        base_hi = st_reg.run && st_reg.hi.clk_prev && !lvl_hi;
        base_lo = st_reg.run && st_reg.lo.clk_prev && !lvl_lo;
        st_next.hi.clk_prev = lvl_hi;
        st_next.lo.clk_prev = lvl_lo;
        // writes only land while the block runs
        wcnt_hi = st_reg.run && wr_en && (wr_sel == CTP_W_CNT_HI);
        wcnt_lo = st_reg.run && wr_en && (wr_sel == CTP_W_CNT_LO);
        wa_hi   = st_reg.run && wr_en && (wr_sel == CTP_W_CORA_HI);
        wb_hi   = st_reg.run && wr_en && (wr_sel == CTP_W_CORB_HI);
        wa_lo   = st_reg.run && wr_en && (wr_sel == CTP_W_CORA_LO);
        wb_lo   = st_reg.run && wr_en && (wr_sel == CTP_W_CORB_LO);
        // upper match a as seen by the match count mode
        ma_pre = match_hit(st_reg.hi.cnt, st_reg.hi.cora, base_hi, wa_hi);
        // capture pin: two stages, then edge detect on the second
        st_next.cap_s1   = capture_input_signal;
        st_next.cap_s2   = st_reg.cap_s1;
        st_next.cap_prev = st_reg.cap_s2;
        rise = st_reg.cap_s2 && !st_reg.cap_prev;
        fall = !st_reg.cap_s2 && st_reg.cap_prev;
        // external clear pin, same treatment
        st_next.clr_s1   = upper_external_clear_input;
        st_next.clr_s2   = st_reg.clr_s1;
        st_next.clr_prev = st_reg.clr_s2;
        ext_clr = st_reg.run && st_reg.clr_s2 && !st_reg.clr_prev;
        // capture sequencing
        cap_go   = 1'b0;
        cap_fire = 1'b0;
        if (!capture_source_select || !st_reg.run) begin
            st_next.cap_arm  = 1'b0;
            st_next.cap_pend = 1'b0;
        end else begin
            if (rise) begin
                st_next.cap_arm = 1'b1;
            end else if (fall && st_reg.cap_arm) begin
                st_next.cap_arm = 1'b0;
                cap_go          = 1'b1;
            end
            cap_go = cap_go || st_reg.cap_pend;
            if (cap_go && cap_rd) begin
                st_next.cap_pend = 1'b1;
            end else begin
                st_next.cap_pend = 1'b0;
                cap_fire         = cap_go;
            end
        end
        if (cap_fire) begin
            st_next.cap_rise = st_reg.lo.cnt;
            st_next.cap_fall = st_reg.lo.cnt;
        end
        st_next.cap_flag = cap_fire | (st_reg.cap_flag & !capture_flag_clear);
        // count events per mode; both modes at once starve both
        if (m16 && mcm) begin
            evt_lo = 1'b0;
        end else if (mcm) begin
            evt_lo = ma_pre;
        end else begin
            evt_lo = base_lo;
        end
        step_lo = chan_step(st_reg.lo, cfg_lo, evt_lo, 1'b0, wcnt_lo,
                            wa_lo, wb_lo, cap_fire, wr_data,
                            flag_clr_lo);
        if (m16 && mcm) begin
            evt_hi = 1'b0;
        end else if (m16) begin
            evt_hi = step_lo.ov;
        end else begin
            evt_hi = base_hi;
        end
        // upper clears act on the upper byte only
        step_hi = chan_step(st_reg.hi, cfg_hi, evt_hi, ext_clr, wcnt_hi,
                            wa_hi, wb_hi, 1'b0, wr_data,
                            flag_clr_hi);
        st_next.hi          = step_hi.ch;
        st_next.hi.clk_prev = lvl_hi;
        st_next.lo          = step_lo.ch;
        st_next.lo.clk_prev = lvl_lo;
    end

    // ****************************************
    // registers
    // ****************************************

    // reset leaves counting halted and compares at their top value
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_reg         <= '0;
            st_reg.hi.cora <= `CTP_COR_RST;
            st_reg.hi.corb <= `CTP_COR_RST;
            st_reg.lo.cora <= `CTP_COR_RST;
            st_reg.lo.corb <= `CTP_COR_RST;
            st_reg.run     <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************

    assign up_counter_hi         = st_reg.hi.cnt;
    assign up_counter_lo         = st_reg.lo.cnt;
    assign capture_rise_register = st_reg.cap_rise;
    assign capture_fall_register = st_reg.cap_fall;
    assign flags_hi              = st_reg.hi.flag;
    assign flags_lo              = st_reg.lo.flag;
    assign capture_flag          = st_reg.cap_flag;
    assign upper_timer_output    = st_reg.hi.pin;
    assign lower_timer_output    = st_reg.lo.pin;

    // both channels feed one line per kind
    assign match_a_interrupt =
        (st_reg.hi.flag.a & cfg_hi.match_a_interrupt_enable) |
        (st_reg.lo.flag.a & cfg_lo.match_a_interrupt_enable);
    assign match_b_interrupt =
        (st_reg.hi.flag.b & cfg_hi.match_b_interrupt_enable) |
        (st_reg.lo.flag.b & cfg_lo.match_b_interrupt_enable);
    assign overflow_interrupt =
        (st_reg.hi.flag.ov & cfg_hi.overflow_interrupt_enable) |
        (st_reg.lo.flag.ov & cfg_lo.overflow_interrupt_enable);
    assign capture_interrupt = st_reg.cap_flag & capture_interrupt_enable;

    assign irq_any = match_a_interrupt | match_b_interrupt |
                     overflow_interrupt | capture_interrupt;

    // fixed ranking of the pending requests
    always_comb begin
        if (match_a_interrupt) begin
            irq_top = 2'h0;
        end else if (match_b_interrupt) begin
            irq_top = 2'h1;
        end else if (overflow_interrupt) begin
            irq_top = 2'h2;
        end else begin
            irq_top = 2'h3;
        end
    end

endmodule // ctp_timer_pair

// file: tb/ctp_pin_model.sv
// capture pin driver standing in for the outside world
`timescale 1ns/1ps
module ctp_pin_model (
    input  wire logic clk_sys,   // system clock
    input  wire logic go,        // start one pulse
    output logic      pin        // capture pin level
);
    // ****************************************
    // pulse shaper
    // ****************************************
    logic [1:0] left = 2'h0;     // cycles of pulse still to run
    initial pin = 1'b0;
    // high for three cycles: wide enough for the two-flop synchroniser
    always @(posedge clk_sys) begin
        if (go) begin
            left <= 2'h3;
            pin  <= 1'b1;        // rise arms the capture
        end else if (left != 2'h0) begin
            left <= left - 2'h1;
            pin  <= (left != 2'h1);
        end
    end
endmodule // ctp_pin_model

// file: tb/ctp_timer_pair_sva.sv
// assertion checker for the cascaded timer pair
`timescale 1ns/1ps
module ctp_timer_pair_sva
    import ctp_pkg::*;
(
    input wire logic       clk_sys,                   // system clock
    input wire logic       rst_b,                     // async reset, low
    input wire logic       module_stop,               // halt level
    input wire ctp_cfg_s   cfg_hi,                    // upper setup
    input wire ctp_cfg_s   cfg_lo,                    // lower setup
    input wire logic       upper_cascade_select,      // 16-bit select
    input wire logic       lower_cascade_select,      // match count select
    input wire logic       capture_interrupt_enable,  // capture req enable
    input wire logic       wr_en,                     // write strobe
    input wire ctp_wsel_e  wr_sel,                    // write target
    input wire logic [7:0] wr_data,                   // write data
    input wire logic       cap_rd,                    // capture read
    input wire logic [7:0] up_counter_hi,             // upper count
    input wire logic [7:0] up_counter_lo,             // lower count
    input wire logic [7:0] capture_rise_register,     // capture copy 1
    input wire logic [7:0] capture_fall_register,     // capture copy 2
    input wire ctp_flag_s  flags_hi,                  // upper flags
    input wire ctp_flag_s  flags_lo,                  // lower flags
    input wire logic       capture_flag,              // capture flag
    input wire logic       match_a_interrupt,         // match a req
    input wire logic       match_b_interrupt,         // match b req
    input wire logic       overflow_interrupt,        // overflow req
    input wire logic       capture_interrupt,         // capture req
    input wire logic       irq_any,                   // any req
    input wire logic [1:0] irq_top                    // top req
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // run flop lags module stop by one edge, hence two samples
    sequence s_halted;
        module_stop [*2];
    endsequence
    sequence s_lo_write;
        !module_stop ##1 (!module_stop && wr_en && wr_sel == CTP_W_CNT_LO
            && !cfg_lo.clear_select_high && !cfg_lo.clear_select_low);
    endsequence
    // ext clear excluded: it would legally move the upper byte
    sequence s_both_modes;
        (cfg_hi.count_clock_select == 3'h4 && upper_cascade_select && !wr_en
            && cfg_lo.count_clock_select == 3'h4 && lower_cascade_select
            && !cfg_hi.clear_select_high) [*2];
    endsequence
    property p_halt;
        s_halted |=> $stable(up_counter_hi) && $stable(up_counter_lo);
    endproperty
    a_halt: assert property (p_halt) else $error("counter moved while halted");
    property p_write;
        s_lo_write |=> up_counter_lo == $past(wr_data);
    endproperty
    a_write: assert property (p_write) else $error("counter write lost");
    property p_both;
        s_both_modes |=> $stable(up_counter_hi) && $stable(up_counter_lo);
    endproperty
    a_both: assert property (p_both) else $error("count with both modes");
    property p_ovf;
        ($rose(flags_lo.ov) |-> up_counter_lo == 8'h00)
            and ($rose(flags_hi.ov) |-> up_counter_hi == 8'h00);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag without wrap");
    property p_cap_pair;
        $rose(capture_flag) |-> capture_rise_register == capture_fall_register;
    endproperty
    a_cap_pair: assert property (p_cap_pair) else $error("capture copies differ");
    property p_cap_hold;
        cap_rd |=> $stable(capture_rise_register) && $stable(capture_fall_register);
    endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("capture during read");
    property p_irq_a;
        match_a_interrupt == ((flags_hi.a & cfg_hi.match_a_interrupt_enable)
            | (flags_lo.a & cfg_lo.match_a_interrupt_enable));
    endproperty
    a_irq_a: assert property (p_irq_a) else $error("shared match a request wrong");
    property p_irq_cap;
        capture_interrupt == (capture_flag & capture_interrupt_enable);
    endproperty
    a_irq_cap: assert property (p_irq_cap) else $error("capture request wrong");
    property p_irq_any;
        irq_any == (match_a_interrupt | match_b_interrupt
            | overflow_interrupt | capture_interrupt);
    endproperty
    a_irq_any: assert property (p_irq_any) else $error("any request wrong");
    property p_irq_top;
        irq_top == (match_a_interrupt ? 2'h0 : match_b_interrupt ? 2'h1
            : overflow_interrupt ? 2'h2 : 2'h3);
    endproperty
    a_irq_top: assert property (p_irq_top) else $error("request priority wrong");
endmodule // ctp_timer_pair_sva
bind ctp_timer_pair ctp_timer_pair_sva u_sva (.*);

// file: tb/ctp_timer_pair_tb.sv
// self-checking bench for the cascaded timer pair
`timescale 1ns/1ps
module ctp_timer_pair_tb
    import ctp_pkg::*;
;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic       clk_sys = 1'b0, rst_b = 1'b0, module_stop = 1'b1;
    ctp_cfg_s   cfg_hi = '0, cfg_lo = '0;             // channel setups
    logic       upper_cascade_select = 1'b0, lower_cascade_select = 1'b0;
    logic       capture_source_select = 1'b0, capture_interrupt_enable = 1'b1;
    wire logic  capture_input_signal;                 // from pin model
    logic       upper_external_clear_input = 1'b0;    // clear pin idle
    logic       wr_en = 1'b0, cap_rd = 1'b0, cap_go = 1'b0;
    ctp_wsel_e  wr_sel = CTP_W_CNT_HI;
    logic [7:0] wr_data = 8'h00, snap_hi, snap_lo;
    ctp_flag_s  flag_clr_hi = '0, flag_clr_lo = '0, flags_hi, flags_lo;
    logic       capture_flag_clear = 1'b0, capture_flag;
    logic [7:0] up_counter_hi, up_counter_lo;
    logic [7:0] capture_rise_register, capture_fall_register;
    logic       upper_timer_output, lower_timer_output, irq_any;
    logic       match_a_interrupt, match_b_interrupt;
    logic       overflow_interrupt, capture_interrupt;
    logic [1:0] irq_top;
    int         fails = 0, n_tests = 0, i;
    always #5 clk_sys = ~clk_sys;
    ctp_timer_pair uut (.*);
    ctp_pin_model  u_pin (.clk_sys(clk_sys), .go(cap_go), .pin(capture_input_signal));
    // ****************************************
    // helpers
    // ****************************************
    // inputs always move 1 ns after the edge so sampling never races
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // strobe drops for a cycle between writes
    task automatic wr(input ctp_wsel_e s, input logic [7:0] d);
        wr_en = 1'b1; wr_sel = s; wr_data = d;
        tick(1);
        wr_en = 1'b0;
        tick(1);
    endtask
    task automatic clr();
        flag_clr_hi = '1; flag_clr_lo = '1; capture_flag_clear = 1'b1;
        tick(1);
        flag_clr_hi = '0; flag_clr_lo = '0; capture_flag_clear = 1'b0;
        tick(1);
    endtask
    task automatic pulse();
        cap_go = 1'b1;
        tick(1);
        cap_go = 1'b0;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        tick(4);
        rst_b = 1'b1;
        tick(2);
        wr(CTP_W_CNT_LO, 8'h5a);
        chk("halted_write", 8'h00, up_counter_lo);
        module_stop = 1'b0;
        tick(2);
        wr(CTP_W_CNT_LO, 8'h5a);
        chk("running_write", 8'h5a, up_counter_lo);
        $display("test module_stop ended");
        // wrap from all ones with overflow request
        cfg_lo.overflow_interrupt_enable = 1'b1;
        wr(CTP_W_CNT_LO, 8'hff);
        cfg_lo.count_clock_select = 3'h1;
        for (i = 0; i < 40 && flags_lo.ov !== 1'b1; i++) tick(1);
        chk("ovf_flag", 8'h01, flags_lo.ov);
        chk("ovf_count", 8'h00, up_counter_lo);
        chk("ovf_req", 8'h01, overflow_interrupt);
        chk("ovf_top", 8'h02, irq_top);
        cfg_lo = '0;
        clr();
        $display("test overflow ended");
        // A and B match together: drive1 beats drive0, toggle beats drive1
        wr(CTP_W_CORA_LO, 8'h03);
        wr(CTP_W_CORB_LO, 8'h03);
        wr(CTP_W_CNT_LO, 8'h00);
        cfg_lo.pin_action_select = {2'h2, 2'h1};
        cfg_lo.clear_select_low = 1'b1;
        cfg_lo.match_a_interrupt_enable = 1'b1;
        cfg_lo.count_clock_select = 3'h1;
        for (i = 0; i < 40 && flags_lo.a !== 1'b1; i++) tick(1);
        chk("match_flag_b", 8'h01, flags_lo.b);
        chk("match_clear", 8'h00, up_counter_lo);
        chk("pin_one_wins", 8'h01, lower_timer_output);
        chk("match_req", 8'h01, match_a_interrupt);
        chk("match_top", 8'h00, irq_top);
        cfg_lo.pin_action_select = {2'h3, 2'h2};
        clr();
        for (i = 0; i < 40 && flags_lo.a !== 1'b1; i++) tick(1);
        chk("pin_toggle_wins", 8'h00, lower_timer_output);
        cfg_lo = '0;
        clr();
        $display("test compare ended");
        // 16-bit: low byte wrap carries into high byte
        wr(CTP_W_CNT_HI, 8'h12);
        wr(CTP_W_CNT_LO, 8'hfe);
        cfg_hi.count_clock_select = 3'h4;
        upper_cascade_select = 1'b1;
        cfg_lo.count_clock_select = 3'h1;
        for (i = 0; i < 40 && up_counter_hi !== 8'h13; i++) tick(1);
        chk("carry_hi", 8'h13, up_counter_hi);
        chk("carry_lo", 8'h00, up_counter_lo);
        cfg_lo.count_clock_select = 3'h4;
        lower_cascade_select = 1'b1;
        tick(2);
        snap_hi = up_counter_hi;
        snap_lo = up_counter_lo;
        tick(40);
        chk("both_hi", snap_hi, up_counter_hi);
        chk("both_lo", snap_lo, up_counter_lo);
        {cfg_hi.clear_select_high, cfg_hi.clear_select_low} = 2'h3;
        upper_external_clear_input = 1'b1;
        tick(5);
        chk("ext_clr_hi", 8'h00, up_counter_hi);
        chk("ext_clr_lo", snap_lo, up_counter_lo);
        $display("test sixteen_bit ended");
        // lower counts upper match A events
        upper_cascade_select = 1'b0;
        cfg_hi.count_clock_select = 3'h1;
        {cfg_hi.clear_select_high, cfg_hi.clear_select_low} = 2'h1;
        cfg_hi.pin_action_select = 4'h2;
        wr(CTP_W_CORA_HI, 8'h01);
        wr(CTP_W_CNT_HI, 8'h00);
        wr(CTP_W_CNT_LO, 8'h00);
        for (i = 0; i < 60 && up_counter_lo !== 8'h02; i++) tick(1);
        chk("match_count", 8'h02, up_counter_lo);
        chk("upper_pin", 8'h01, upper_timer_output);
        cfg_hi = '0;
        cfg_lo = '0;
        lower_cascade_select = 1'b0;
        $display("test match_count ended");
        // capture: gated, normal, then held off by a read
        wr(CTP_W_CNT_LO, 8'h37);
        clr();
        pulse();
        tick(12);
        chk("capture_off", 8'h00, capture_flag);
        capture_source_select = 1'b1;
        pulse();
        for (i = 0; i < 12 && capture_flag !== 1'b1; i++) tick(1);
        chk("capture_rise", 8'h37, capture_rise_register);
        chk("capture_fall", 8'h37, capture_fall_register);
        chk("capture_req", 8'h01, capture_interrupt);
        cap_rd = 1'b1;
        clr();
        wr(CTP_W_CNT_LO, 8'h44);
        pulse();
        tick(10);
        chk("capture_held", 8'h37, capture_rise_register);
        cap_rd = 1'b0;
        tick(2);
        chk("capture_late", 8'h44, capture_fall_register);
        $display("test capture ended");
        final_report();
    end
    // watchdog: the tests need well under 2000 cycles
    initial begin
        #50000;
        fails++;
        final_report();
    end
endmodule // ctp_timer_pair_tb
